// file: verilog/ssc_pkg.sv
// Purpose: Shared constants and types for the strap sampling block
// Assumes: Register port with 8-bit address and 8-bit data
// Notes: Offsets are byte addresses on the plain register port
package ssc_pkg;
    // Register port
    localparam int unsigned ADDR_W = 8;
    localparam int unsigned DATA_W = 8;
    localparam logic [7:0] OFF_STRAP_TWO = 8'h4c;
    localparam logic [7:0] OFF_HCLK = 8'h5f;
    localparam logic [7:0] OFF_STATUS = 8'h60;
    localparam logic [7:0] RDATA_RST = 8'h00;

    // Memory data bus
    localparam int unsigned MDL_W = 44;
    localparam logic [43:0] MDL_OE_OFF = 44'h000_0000_0000;
    localparam logic [43:0] MDL_OUT_RST = 44'h000_0000_0000;

    // Strap word two layout
    localparam int unsigned S2_W = 6;
    localparam int unsigned S2_LOW_LSB = 16;
    localparam int unsigned S2_LOW_MSB = 20;
    localparam int unsigned S2_B5_LINE = 23;
    localparam int unsigned S2_B5_BIT = 5;
    localparam int unsigned S2_WR_BIT = 4;
    localparam logic [5:0] S2_WMASK = 6'h10;
    localparam logic [5:0] S2_RST = 6'h00;
    localparam int unsigned PCI_DIV_BIT = 1;

    // Host clock strap layout
    localparam int unsigned HC_W = 6;
    localparam int unsigned HC_LSB = 21;
    localparam int unsigned HC_MSB = 26;
    localparam int unsigned SYN_LSB = 3;
    localparam int unsigned SYN_MSB = 5;
    localparam logic [5:0] HC_WMASK = 6'h00;
    localparam logic [5:0] HC_RST = 6'h00;

    // Core multiplier strap
    localparam int unsigned CORE_LINE = 40;

    // Status register bits
    localparam int unsigned ST_CORE_BIT = 0;
    localparam int unsigned ST_RUN_BIT = 1;

    // PCI clock divisors
    localparam logic [1:0] DIV_BY_2 = 2'h2;
    localparam logic [1:0] DIV_BY_3 = 2'h3;
    localparam logic [1:0] CNT_RST = 2'h0;

    typedef enum logic {SSC_CAPTURE, SSC_RUN} ssc_phase_t;
endpackage

// file: verilog/ssc_field_if.sv
// Purpose: Carrier between the top and one strap field register
// Assumes: Owner drives load, capture value and write port
// Notes: Width follows the field
`timescale 1ns/1ps
interface ssc_field_if #(parameter int unsigned W = 6);
    logic load;
    logic [W-1:0] cap;
    logic wr;
    logic [W-1:0] wdata;
    logic [W-1:0] value;
    modport owner (output load, output cap, output wr, output wdata, input value);
    modport field (input load, input cap, input wr, input wdata, output value);
endinterface

// file: verilog/ssc_cap_field.sv
// Purpose: One strap field, loaded at capture, optionally partly writable
// Assumes: Load and write never meet; load wins if they do
// Notes: WMASK selects the bits software may change
`timescale 1ns/1ps
module ssc_cap_field
    import ssc_pkg::*;
#(
    parameter int unsigned W = 6,
    parameter logic [W-1:0] WMASK = '0,
    parameter logic [W-1:0] RST = '0
) (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic rst_n,
    // Field carrier
    ssc_field_if.field fif
);
    typedef struct packed {
        logic [W-1:0] val;
    } ssc_field_st_t;

    ssc_field_st_t st_ff;
    ssc_field_st_t nxt_st;

    always_comb begin
        nxt_st = st_ff;
        if (fif.load) begin
            nxt_st.val = fif.cap;
        end else if (fif.wr) begin
            nxt_st.val = (st_ff.val & ~WMASK) | (fif.wdata & WMASK);
        end
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            st_ff <= '{val: RST};
        end else begin
            st_ff <= nxt_st;
        end
    end

    assign fif.value = st_ff.val;
endmodule

// file: verilog/ssc_clk_div.sv
// Purpose: PCI clock output divider from the host clock
// Assumes: Divisor steady while running
// Notes: High for one host cycle per output period
`timescale 1ns/1ps
module ssc_clk_div
    import ssc_pkg::*;
(
    // Clock and reset
    input wire logic clk_sys,
    input wire logic rst_n,
    // Control
    input wire logic run,
    input wire logic div_by_3,
    // Output clock
    output logic pci_clk
);
    typedef struct packed {
        logic [1:0] cnt;
        logic clk_out;
    } ssc_div_st_t;

    ssc_div_st_t st_ff;
    ssc_div_st_t nxt_st;
    logic [1:0] last;

    always_comb begin
        nxt_st = st_ff;
        last = (div_by_3 ? DIV_BY_3 : DIV_BY_2) - 2'h1;
        if (!run) begin
            nxt_st.cnt = CNT_RST;
            nxt_st.clk_out = 1'b0;
        end else begin
            nxt_st.cnt = (st_ff.cnt >= last) ? CNT_RST : st_ff.cnt + 2'h1;
            nxt_st.clk_out = (nxt_st.cnt == CNT_RST);
        end
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            st_ff <= '{cnt: CNT_RST, clk_out: 1'b0};
        end else begin
            st_ff <= nxt_st;
        end
    end

    assign pci_clk = st_ff.clk_out;
endmodule

// file: verilog/ssc_strap_top.sv
// Purpose: Strap capture at reset and the strap registers
// Assumes: Memory data lines synchronous to clk_sys; board straps only
// Notes: Capture happens on the first edge after reset release
//
// Local design decision: the address-and-strobe port.
`timescale 1ns/1ps

// Operation
// - Strap word two bits 4 to 0 show memory data lines 20 to 16 as captured.
// - Strap word two bit 5 shows memory data line 23 as captured.
// - Only bit 4 of strap word two takes software writes; other bits keep their value.
// - Strap word two bit 1 picks the PCI clock output, 0 for host clock over 2, 1 over 3.
// - Strap word two loads lines 23 and 20 to 16 after every reset.
// - Host clock strap bits 5 to 0 show memory data lines 26 to 21 as captured.
// - Host clock strap bits 5 to 3 from lines 26 to 24 set the host clock synthesizer.
// - Host clock strap loads its lines after every reset.
// - Memory data line 40 low gives single speed core, high gives double speed core.
// - Strap lines 43 to 41 and 39 to 27 have no function.
// - Strap lines 15 to 0 have no configuration function.
module ssc_strap_top
    import ssc_pkg::*;
(
    // Clock and reset
    input wire logic clk_sys,
    input wire logic rst_n,
    // Register port
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [7:0] reg_rdata,
    // Memory data lines
    input wire logic [43:0] memory_data_line_in,
    output logic [43:0] memory_data_line_out,
    output logic [43:0] memory_data_line_oe,
    // Memory controller drive request
    input wire logic [43:0] mem_ctrl_wdata,
    input wire logic mem_ctrl_drive,
    // Configuration outputs
    output logic pci_clock_output,
    output logic [2:0] hclk_synth_sel,
    output logic double_speed_core,
    output logic strap_valid
);
    typedef struct packed {
        ssc_phase_t phase;
        logic core_x2;
        logic [7:0] rdata;
        logic [43:0] line_out;
        logic [43:0] line_oe;
    } ssc_top_st_t;

    ssc_top_st_t st_ff;
    ssc_top_st_t nxt_st;

    ssc_field_if #(.W(S2_W)) s2_if ();
    ssc_field_if #(.W(HC_W)) hc_if ();

    logic capture;
    logic run;
    logic [5:0] s2_val;
    logic [5:0] hc_val;

    assign capture = (st_ff.phase == SSC_CAPTURE);
    assign run = (st_ff.phase == SSC_RUN);
    assign s2_val = s2_if.value;
    assign hc_val = hc_if.value;

    // Strap word two, bit 4 writable
    assign s2_if.load = capture;
    assign s2_if.cap = {memory_data_line_in[S2_B5_LINE],
                        memory_data_line_in[S2_LOW_MSB:S2_LOW_LSB]};
    assign s2_if.wr = run && reg_wr && (reg_addr == OFF_STRAP_TWO);
    assign s2_if.wdata = reg_wdata[5:0];

    ssc_cap_field #(
        .W(S2_W),
        .WMASK(S2_WMASK),
        .RST(S2_RST)
    ) u_strap_word_two (
        .clk_sys(clk_sys),
        .rst_n(rst_n),
        .fif(s2_if.field)
    );

    // Host clock strap, read only
    assign hc_if.load = capture;
    assign hc_if.cap = memory_data_line_in[HC_MSB:HC_LSB];
    assign hc_if.wr = 1'b0;
    assign hc_if.wdata = HC_RST;

    ssc_cap_field #(
        .W(HC_W),
        .WMASK(HC_WMASK),
        .RST(HC_RST)
    ) u_host_clock_strap_word (
        .clk_sys(clk_sys),
        .rst_n(rst_n),
        .fif(hc_if.field)
    );

    ssc_clk_div u_pci_div (
        .clk_sys(clk_sys),
        .rst_n(rst_n),
        .run(run),
        .div_by_3(s2_val[PCI_DIV_BIT]),
        .pci_clk(pci_clock_output)
    );

    always_comb begin
        nxt_st = st_ff;
        nxt_st.rdata = RDATA_RST;
        case (st_ff.phase)
            SSC_CAPTURE: begin
                // Bus still floated so only the board resistors set the level
                nxt_st.core_x2 = memory_data_line_in[CORE_LINE];
                nxt_st.phase = SSC_RUN;
                nxt_st.line_oe = MDL_OE_OFF;
            end
            SSC_RUN: begin
                // Captured straps are never reloaded until the next reset
                nxt_st.phase = SSC_RUN;
                nxt_st.line_out = mem_ctrl_wdata;
                nxt_st.line_oe = {MDL_W{mem_ctrl_drive}};
                if (reg_rd) begin
                    case (reg_addr)
                        OFF_STRAP_TWO: nxt_st.rdata = {2'h0, s2_val};
                        OFF_HCLK: nxt_st.rdata = {2'h0, hc_val};
                        OFF_STATUS: begin
                            nxt_st.rdata[ST_CORE_BIT] = st_ff.core_x2;
                            nxt_st.rdata[ST_RUN_BIT] = 1'b1;
                        end
                        default: nxt_st.rdata = RDATA_RST;
                    endcase
                end
            end
            default: begin
                nxt_st.phase = SSC_CAPTURE;
                nxt_st.line_oe = MDL_OE_OFF;
            end
        endcase
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            st_ff <= '{phase: SSC_CAPTURE, core_x2: 1'b0, rdata: RDATA_RST,
                       line_out: MDL_OUT_RST, line_oe: MDL_OE_OFF};
        end else begin
            st_ff <= nxt_st;
        end
    end

    // Lines 43..41, 39..27 and 15..0 feed no logic
    assign reg_rdata = st_ff.rdata;
    assign memory_data_line_out = st_ff.line_out;
    assign memory_data_line_oe = st_ff.line_oe;
    assign hclk_synth_sel = hc_val[SYN_MSB:SYN_LSB];
    assign double_speed_core = st_ff.core_x2;
    assign strap_valid = run;

    // Checks
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (!rst_n);

    // Capture checks key on run rising, so the release edge cannot start a stale attempt
    property p_s2_low;
        $rose(run) |-> s2_val[4:0] == $past(memory_data_line_in[20:16]);
    endproperty
    a_s2_low: assert property (p_s2_low) else $error("strap word two low bits wrong");

    property p_s2_b5;
        $rose(run) |-> s2_val[S2_B5_BIT] == $past(memory_data_line_in[23]);
    endproperty
    a_s2_b5: assert property (p_s2_b5) else $error("strap word two bit 5 wrong");

    property p_s2_write;
        run && reg_wr && reg_addr == OFF_STRAP_TWO |=>
            s2_val[3:0] == $past(s2_val[3:0]) && s2_val[5] == $past(s2_val[5])
            && s2_val[S2_WR_BIT] == $past(reg_wdata[4]);
    endproperty
    a_s2_write: assert property (p_s2_write) else $error("strap word two write wrong");

    property p_s2_other;
        run && reg_wr && reg_addr != OFF_STRAP_TWO |=>
            $stable(s2_val);
    endproperty
    a_s2_other: assert property (p_s2_other) else $error("stray strap two write");

    property p_s2_hold;
        run && !reg_wr |=> $stable(s2_val);
    endproperty
    a_s2_hold: assert property (p_s2_hold) else $error("strap word two moved");

    property p_s2_read;
        run && reg_rd && reg_addr == OFF_STRAP_TWO |=>
            reg_rdata == {2'h0, $past(s2_val)};
    endproperty
    a_s2_read: assert property (p_s2_read) else $error("strap word two read wrong");

    property p_pci_idle;
        !run |-> !pci_clock_output;
    endproperty
    a_pci_idle: assert property (p_pci_idle) else $error("pci clock before run");

    property p_pci_div2;
        run && $rose(pci_clock_output) && !s2_val[PCI_DIV_BIT] |->
            ##1 !pci_clock_output ##1 pci_clock_output;
    endproperty
    a_pci_div2: assert property (p_pci_div2) else $error("pci clock not host over 2");

    property p_pci_div3;
        run && $rose(pci_clock_output) && s2_val[PCI_DIV_BIT] |->
            ##1 !pci_clock_output [*2] ##1 pci_clock_output;
    endproperty
    a_pci_div3: assert property (p_pci_div3) else $error("pci clock not host over 3");

    property p_s2_reset_load;
        $rose(run) |-> s2_val == $past({memory_data_line_in[23], memory_data_line_in[20:16]});
    endproperty
    a_s2_reset_load: assert property (p_s2_reset_load) else $error("strap two not loaded");

    property p_hc_capture;
        $rose(run) |-> hc_val == $past(memory_data_line_in[26:21]);
    endproperty
    a_hc_capture: assert property (p_hc_capture) else $error("host clock strap wrong");

    property p_hc_read;
        run && reg_rd && reg_addr == OFF_HCLK |=>
            reg_rdata == {2'h0, $past(hc_val)};
    endproperty
    a_hc_read: assert property (p_hc_read) else $error("host clock strap read wrong");

    property p_synth_sel;
        $rose(run) |-> hclk_synth_sel == $past(memory_data_line_in[26:24]);
    endproperty
    a_synth_sel: assert property (p_synth_sel) else $error("synthesizer select wrong");

    property p_synth_hold;
        run |=> $stable(hclk_synth_sel);
    endproperty
    a_synth_hold: assert property (p_synth_hold) else $error("synth select moved");

    property p_hc_hold;
        run |=> $stable(hc_val);
    endproperty
    a_hc_hold: assert property (p_hc_hold) else $error("host clock strap changed");

    property p_core_speed;
        $rose(run) |-> double_speed_core == $past(memory_data_line_in[40]);
    endproperty
    a_core_speed: assert property (p_core_speed) else $error("core multiplier wrong");

    property p_core_hold;
        run |=> $stable(double_speed_core) && run;
    endproperty
    a_core_hold: assert property (p_core_hold) else $error("core multiplier changed");

    property p_core_status;
        run && reg_rd && reg_addr == OFF_STATUS |=>
            reg_rdata[ST_CORE_BIT] == $past(double_speed_core) && reg_rdata[ST_RUN_BIT];
    endproperty
    a_core_status: assert property (p_core_status) else $error("status read wrong");

    property p_rdata_idle;
        !(run && reg_rd) |=> reg_rdata == RDATA_RST;
    endproperty
    a_rdata_idle: assert property (p_rdata_idle) else $error("read data not idle");

    property p_rdata_unmapped;
        run && reg_rd && reg_addr != OFF_STRAP_TWO && reg_addr != OFF_HCLK
            && reg_addr != OFF_STATUS |=> reg_rdata == RDATA_RST;
    endproperty
    a_rdata_unmapped: assert property (p_rdata_unmapped) else $error("unmapped read not zero");

    property p_drive_off;
        capture |-> memory_data_line_oe == MDL_OE_OFF;
    endproperty
    a_drive_off: assert property (p_drive_off) else $error("bus driven during capture");

    property p_drive_follow;
        run |=> memory_data_line_oe == {MDL_W{$past(mem_ctrl_drive)}}
            && memory_data_line_out == $past(mem_ctrl_wdata);
    endproperty
    a_drive_follow: assert property (p_drive_follow) else $error("bus drive wrong");

    property p_capture_once;
        $rose(run) |-> ##1 run ##1 run;
    endproperty
    a_capture_once: assert property (p_capture_once) else $error("capture not single");

    c_capture: cover property (capture ##1 run);
    c_s2_write: cover property (run && reg_wr && reg_addr == OFF_STRAP_TWO);
    c_div3: cover property (run && s2_val[PCI_DIV_BIT] && $rose(pci_clock_output));
    c_div2: cover property (run && !s2_val[PCI_DIV_BIT] && $rose(pci_clock_output));
    c_status_read: cover property (run && reg_rd && reg_addr == OFF_STATUS);
endmodule

// file: verif/ssc_strap_board.sv
// Purpose: Board strap resistors on the memory data lines
// Assumes: Fitted lines settle to their level while the device is not driving
// Notes: Unfitted lines other than 40 churn every cycle so stale values never look valid
`timescale 1ns/1ps
module ssc_strap_board (
    // Clock
    input wire logic clk_sys,
    // Board fitting
    input wire logic [43:0] strap_lvl,
    input wire logic [43:0] strap_fit,
    // Device side
    input wire logic [43:0] dev_out,
    input wire logic [43:0] dev_oe,
    output logic [43:0] lines
);
    localparam logic [43:0] PD_MASK = 44'h100_0000_0000;
    logic [43:0] churn_ff = 44'ha5a_5a5a_5a5a;

    always_ff @(posedge clk_sys) begin
        churn_ff <= ~churn_ff;
    end

    // Line 40 unfitted falls to its default pull-down
    always_comb begin
        lines = (dev_oe & dev_out) | (~dev_oe & strap_fit & strap_lvl)
            | (~dev_oe & ~strap_fit & churn_ff & ~PD_MASK);
    end
endmodule

// file: verif/tb_ssc_strap_top.sv
// Purpose: Self-checking bench for the strap capture block
// Assumes: Straps set before reset release; register port per hand-over timing
// Notes: Two inverse strap patterns catch stuck and swapped bits
`timescale 1ns/1ps
module tb_ssc_strap_top;
    import ssc_pkg::*;
    localparam logic [43:0] PAT_A = 44'h9e3_6c7a_5a5a;
    localparam logic [43:0] PAT_B = 44'h61c_9385_a5a5;
    localparam logic [43:0] FIT = 44'hfff_ffff_0000;
    logic clk_sys, rst_n, reg_wr, reg_rd, mc_drive, pci_out, dsc, strap_valid;
    logic [7:0] reg_addr, reg_wdata, reg_rdata;
    logic [2:0] synth_sel;
    logic [43:0] ln_in, ln_out, ln_oe, mc_wdata, s_lvl, s_fit;
    int miscompares = 0;
    int total_checks = 0;

    initial begin
        clk_sys = 1'b0;
        forever #12.5 clk_sys = ~clk_sys;
    end

    ssc_strap_top dut (.clk_sys(clk_sys), .rst_n(rst_n), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .memory_data_line_in(ln_in), .memory_data_line_out(ln_out),
        .memory_data_line_oe(ln_oe), .mem_ctrl_wdata(mc_wdata), .mem_ctrl_drive(mc_drive),
        .pci_clock_output(pci_out), .hclk_synth_sel(synth_sel),
        .double_speed_core(dsc), .strap_valid(strap_valid));

    ssc_strap_board board (.clk_sys(clk_sys), .strap_lvl(s_lvl), .strap_fit(s_fit),
        .dev_out(ln_out), .dev_oe(ln_oe), .lines(ln_in));

    task automatic finish_test;
        if (miscompares == 0 && total_checks > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask

    task automatic chk(input logic [43:0] got, input logic [43:0] exp);
        total_checks++;
        if (got !== exp) begin
            miscompares++;
            $display("[ERR] %0t got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic reg_write(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk_sys);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge clk_sys);
        reg_wr <= 1'b0;
    endtask

    task automatic reg_read(input logic [7:0] a, input logic [7:0] exp);
        @(posedge clk_sys);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge clk_sys);
        reg_rd <= 1'b0;
        #1 chk(reg_rdata, exp);
    endtask

    // Reset with straps, then disturb the lines after capture
    task automatic sc_capture(input logic [43:0] lvl, input logic [43:0] fit);
        @(posedge clk_sys);
        rst_n <= 1'b0;
        s_lvl <= lvl;
        s_fit <= fit;
        repeat (8) @(posedge clk_sys);
        #1 chk(ln_oe, 44'h000_0000_0000);
        chk(strap_valid, 1'b0);
        @(posedge clk_sys);
        rst_n <= 1'b1;
        @(posedge clk_sys);
        #1 chk(strap_valid, 1'b1);
        chk(ln_oe, 44'h000_0000_0000);
        @(posedge clk_sys);
        s_lvl <= ~lvl;
    endtask

    task automatic sc_straps(input logic [43:0] s);
        reg_read(OFF_STRAP_TWO, {2'h0, s[23], s[20:16]});
        reg_read(OFF_HCLK, {2'h0, s[26:21]});
        chk(synth_sel, s[26:24]);
        chk(dsc, s[40]);
        reg_read(OFF_STATUS, {6'h00, 1'b1, s[40]});
    endtask

    task automatic wait_pci(output int n);
        n = 0;
        do begin
            @(posedge clk_sys);
            #1 n++;
        end while (pci_out !== 1'b1 && n < 8);
        if (pci_out !== 1'b1) begin
            miscompares++;
            $display("[ERR] %0t pci clock stalled", $time);
            finish_test;
        end
    endtask

    task automatic sc_pci(input int exp);
        int n;
        wait_pci(n);
        wait_pci(n);
        chk(n, exp);
    endtask

    // Only bit 4 of strap word two moves; host clock word is read only
    task automatic sc_regs(input logic [43:0] s);
        logic [7:0] e2;
        e2 = {2'h0, s[23], s[20:16]};
        reg_write(OFF_STRAP_TWO, 8'h00);
        reg_read(OFF_STRAP_TWO, e2 & 8'hef);
        reg_write(OFF_STRAP_TWO, 8'hff);
        reg_read(OFF_STRAP_TWO, e2 | 8'h10);
        reg_write(OFF_HCLK, {2'h3, ~s[26:21]});
        reg_read(OFF_HCLK, {2'h0, s[26:21]});
        reg_read(8'h33, 8'h00);
    endtask

    // Device drives the lines; captured straps must not follow
    task automatic sc_drive(input logic [43:0] s);
        @(posedge clk_sys);
        mc_wdata <= ~s;
        mc_drive <= 1'b1;
        @(posedge clk_sys);
        #1 chk(ln_oe, 44'hfff_ffff_ffff);
        chk(ln_out, ~s);
        @(posedge clk_sys);
        mc_drive <= 1'b0;
        reg_read(OFF_HCLK, {2'h0, s[26:21]});
        chk(dsc, s[40]);
    endtask

    initial begin
        rst_n = 1'b0;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        reg_addr = 8'h00;
        reg_wdata = 8'h00;
        mc_drive = 1'b0;
        mc_wdata = 44'h000_0000_0000;
        s_lvl = PAT_A;
        s_fit = FIT;
        sc_capture(PAT_A, FIT);
        sc_straps(PAT_A);
        sc_pci(3);
        sc_regs(PAT_A);
        sc_drive(PAT_A);
        sc_capture(PAT_B, FIT);
        sc_straps(PAT_B);
        sc_pci(2);
        sc_capture(PAT_A, FIT & 44'heff_ffff_ffff);
        sc_straps(PAT_A & 44'heff_ffff_ffff);
        finish_test;
    end
endmodule
